// ===== src/sync_sram_burst_write_decode.sv
// Burst sequencer, byte write decode and sleep control with AHB status
// Behaviour
// - Interleaved: XOR low bits with position
// - Linear: low bits count modulo four
// - Write: global low, or enable plus lane
// - Global write low writes every lane
// - Otherwise read when no lane enabled
// - Enabled write hits exactly strobed lanes
// - Four lanes wide, two lanes narrow
// - Selected only for low, high, low selects
// - Sleep ignores commands; stays low-power until command
// - Standby within two cycles of sleep
`default_nettype none
module sync_sram_burst_write_decode
  import sram_ctl_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int NLANES = LANES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  // RAM-side control pins
  input wire logic [AW-1:0] addr_in,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic select_primary_n,
  input wire logic select_expand_hi,
  input wire logic select_expand_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [NLANES-1:0] byte_lane_strobe_n,
  input wire logic burst_order_sel,
  input wire logic sleep_req,
  // Array access outputs
  output logic [AW-1:0] mem_addr_q,
  output logic [NLANES-1:0] mem_wr_lane_q,
  output logic mem_rd_q,
  output logic mem_sel_q,
  output logic asleep_q
);
  // The burst counter only touches two address bits
  if (AW < 3) begin : g_bad_aw
    $error("sync_sram_burst_write_decode: AW must be at least 3");
  end

  // Input sample registers (synchronous pins, one stage)
  logic [AW-1:0] p_addr_q;
  logic p_ps_n_q, p_cs_n_q, p_adv_n_q;
  logic p_sp_n_q, p_sh_q, p_se_n_q;
  logic p_gw_n_q, p_bwe_n_q;
  logic [NLANES-1:0] p_lane_n_q;
  // Sleep synchroniser, the pin is asynchronous
  logic sleep_meta_q, sleep_sync_q;
  // Power state and recovery counter
  pwr_state_t state_q;
  logic [REC_CNT_W-1:0] rec_cnt_q;
  // Burst state
  logic burst_act_q;
  logic [1:0] idx_q, idx_d;
  logic [AW-1:0] start_q, start_d;
  logic [1:0] lsb_next;
  // Register file
  logic [31:0] ctrl_q, wr_count_q, rd_count_q;
  logic wr_pend_q;
  logic [7:0] wr_off_q;
  // Cycle decode
  logic awake, chip_en, proc_start, start, begin_op, cont, step;
  logic dec_write, wr_block, do_write, do_read;
  logic [NLANES-1:0] dec_lanes;

  // Sample the synchronous pins; reset holds all strobes inactive
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      p_addr_q <= '0;
      p_ps_n_q <= 1'b1;
      p_cs_n_q <= 1'b1;
      p_adv_n_q <= 1'b1;
      p_sp_n_q <= 1'b1;
      p_sh_q <= 1'b0;
      p_se_n_q <= 1'b1;
      p_gw_n_q <= 1'b1;
      p_bwe_n_q <= 1'b1;
      p_lane_n_q <= '1;
    end else begin
      p_addr_q <= addr_in;
      p_ps_n_q <= proc_addr_strobe_n;
      p_cs_n_q <= ctrl_addr_strobe_n;
      p_adv_n_q <= burst_advance_n;
      p_sp_n_q <= select_primary_n;
      p_sh_q <= select_expand_hi;
      p_se_n_q <= select_expand_n;
      p_gw_n_q <= global_write_n;
      p_bwe_n_q <= byte_write_enable_n;
      p_lane_n_q <= byte_lane_strobe_n;
    end
  end

  // Two-stage synchroniser for the sleep level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sleep_meta_q <= 1'b0;
      sleep_sync_q <= 1'b0;
    end else begin
      sleep_meta_q <= sleep_req;
      sleep_sync_q <= sleep_meta_q;
    end
  end

  // Write decode of the sampled strobes
  byte_write_decode #(.NLANES(NLANES)) u_wdec (
    .global_write_n(p_gw_n_q),
    .byte_write_enable_n(p_bwe_n_q),
    .byte_lane_strobe_n(p_lane_n_q),
    .is_write(dec_write),
    .lane_wr(dec_lanes)
  );

  // Cycle classification
  always_comb begin
    // Commands count only when not asleep or recovering
    awake = (state_q == ST_ACTIVE || state_q == ST_LOWPWR) &&
            !sleep_sync_q;
    chip_en = !p_sp_n_q && p_sh_q && !p_se_n_q;
    // Processor strobe is blocked while the primary select is high
    proc_start = !p_ps_n_q && !p_sp_n_q;
    start = proc_start || !p_cs_n_q;
    begin_op = awake && start && chip_en;
    cont = awake && !start && burst_act_q;
    step = cont && !p_adv_n_q;
    wr_block = ctrl_q[CTRL_WR_BLOCK_BIT];
    // A processor-strobe start always reads
    do_write = ((begin_op && !proc_start) || cont) && dec_write &&
               !wr_block;
    do_read = ((begin_op && (proc_start || !dec_write)) ||
               (cont && !dec_write));
    idx_d = begin_op ? 2'h0 : (step ? 2'(idx_q + 2'h1) : idx_q);
    start_d = begin_op ? p_addr_q : start_q;
  end

  // Low address bits for the coming cycle
  burst_addr_gen u_agen (
    .start_lsb(start_d[1:0]),
    .idx(idx_d),
    .burst_order_sel(burst_order_sel),
    .addr_lsb(lsb_next)
  );

  // Burst sequencer: load on a selected start, drop on deselect
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      burst_act_q <= 1'b0;
      idx_q <= 2'h0;
      start_q <= '0;
      mem_addr_q <= '0;
    end else begin
      if (!awake || (start && !chip_en && !(p_sp_n_q && !p_ps_n_q &&
          p_cs_n_q))) begin
        // Sleep or a true deselect ends the burst
        burst_act_q <= 1'b0;
      end else if (begin_op) begin
        burst_act_q <= 1'b1;
      end
      idx_q <= idx_d;
      start_q <= start_d;
      // Upper bits stay from the external start address
      mem_addr_q <= {start_d[AW-1:2], lsb_next};
    end
  end

  // Array strobes, all forced quiet while not awake
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_wr_lane_q <= '0;
      mem_rd_q <= 1'b0;
      mem_sel_q <= 1'b0;
    end else begin
      mem_wr_lane_q <= do_write ? dec_lanes : '0;
      mem_rd_q <= do_read;
      mem_sel_q <= begin_op || cont;
    end
  end

  // Power state: standby, recovery count, then low power until used
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_ACTIVE;
      rec_cnt_q <= '0;
      asleep_q <= 1'b0;
    end else begin
      asleep_q <= sleep_sync_q;
      case (state_q)
        ST_ACTIVE: begin
          if (sleep_sync_q) begin
            state_q <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!sleep_sync_q) begin
            state_q <= ST_RECOVER;
            rec_cnt_q <= REC_CNT_W'(RECOVER_CNT - 1);
          end
        end
        ST_RECOVER: begin
          // Host keeps quiet here; commands are ignored anyway
          if (sleep_sync_q) begin
            state_q <= ST_STANDBY;
          end else if (rec_cnt_q == '0) begin
            state_q <= ST_LOWPWR;
          end else begin
            rec_cnt_q <= REC_CNT_W'(rec_cnt_q - 1'b1);
          end
        end
        ST_LOWPWR: begin
          if (sleep_sync_q) begin
            state_q <= ST_STANDBY;
          end else if (begin_op) begin
            state_q <= ST_ACTIVE;
          end
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  // Bus: always ready, read data registered in the address phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= '0;
      wr_pend_q <= 1'b0;
      wr_off_q <= '0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      wr_pend_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      wr_off_q <= haddr[7:0];
      if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
        case (haddr[7:0])
          REG_CTRL: hrdata <= ctrl_q;
          REG_STATUS: hrdata <= {24'h0, 4'(state_q), mem_sel_q,
                                 burst_act_q, idx_q};
          REG_WR_COUNT: hrdata <= wr_count_q;
          REG_RD_COUNT: hrdata <= rd_count_q;
          default: hrdata <= '0; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Control register, written in the data phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_pend_q && wr_off_q == REG_CTRL) begin
      ctrl_q <= {30'h0, hwdata[CTRL_CNT_CLR_BIT], hwdata[CTRL_WR_BLOCK_BIT]};
    end else begin
      // Clear request is a one-shot
      ctrl_q[CTRL_CNT_CLR_BIT] <= 1'b0;
    end
  end

  // Cycle counters; a clear and a counted cycle in the same clock leave a count of one
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_count_q <= '0;
      rd_count_q <= '0;
    end else begin
      if (do_write) begin
        wr_count_q <= ctrl_q[CTRL_CNT_CLR_BIT] ? 32'h1 : wr_count_q + 1'b1;
      end else if (ctrl_q[CTRL_CNT_CLR_BIT]) begin
        wr_count_q <= '0;
      end
      if (do_read) begin
        rd_count_q <= ctrl_q[CTRL_CNT_CLR_BIT] ? 32'h1 : rd_count_q + 1'b1;
      end else if (ctrl_q[CTRL_CNT_CLR_BIT]) begin
        rd_count_q <= '0;
      end
    end
  end

  // Checks on the sequencer, decoder and sleep control
  lin_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step && burst_order_sel == ORDER_LINEAR) |=>
      mem_addr_q[1:0] == 2'($past(mem_addr_q[1:0]) + 2'h1))
    else $error("linear burst did not count by one");
  ilv_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step && burst_order_sel != ORDER_LINEAR) |=>
      (mem_addr_q[1:0] ^ $past(start_q[1:0])) == 2'($past(idx_q) + 2'h1))
    else $error("interleaved burst address wrong");
  upper_hold_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    step |=> mem_addr_q[AW-1:2] == $past(mem_addr_q[AW-1:2]))
    else $error("burst changed upper address bits");
  gw_all_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cont && !p_gw_n_q && !wr_block) |=> mem_wr_lane_q == '1)
    else $error("global write missed a lane");
  read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cont && p_gw_n_q && (p_bwe_n_q || &p_lane_n_q)) |=>
      (mem_rd_q && mem_wr_lane_q == '0))
    else $error("read cycle not decoded as read");
  lane_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cont && p_gw_n_q && !p_bwe_n_q && !wr_block) |=>
      mem_wr_lane_q == ~$past(p_lane_n_q))
    else $error("byte write lanes wrong");
  wr_detect_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mem_wr_lane_q != '0) |->
      ($past(p_gw_n_q) == 1'b0 || $past(p_bwe_n_q) == 1'b0))
    else $error("write without a write strobe");
  chip_en_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (start && (p_sp_n_q || !p_sh_q || p_se_n_q)) |=> !mem_sel_q)
    else $error("selected with a select inactive");
  sleep_entry_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    ($rose(sleep_req) ##1 sleep_req ##1 sleep_req) |=>
      (mem_wr_lane_q == '0 && !mem_rd_q))
    else $error("access after standby deadline");
  lowpwr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_LOWPWR && !begin_op) |=> state_q != ST_ACTIVE)
    else $error("left low power without a command");
endmodule // sync_sram_burst_write_decode
`default_nettype wire

// ===== src/sram_ctl_pkg.sv
// Shared constants and types for the burst sequencer and write decoder
`default_nettype none
package sram_ctl_pkg;
  // Array organisation
  localparam int ADDR_W = 18;            // Word address width
  localparam int LANES = 4;              // Byte lanes in the wide build
  // Sleep timing, in RAM clock cycles as specified
  localparam int SLEEP_STANDBY_CYCLES = 2;   // Latest standby entry
  localparam int SLEEP_RECOVERY_CYCLES = 2;  // Recovery before new commands
  localparam int CLK_PERIOD_NS = 10;
  // Counts: a cycle figure is already whole clock periods
  localparam int STANDBY_CNT = SLEEP_STANDBY_CYCLES;
  localparam int RECOVER_CNT = SLEEP_RECOVERY_CYCLES;
  localparam int REC_CNT_W = 2;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WR_COUNT = 8'h08;
  localparam logic [7:0] REG_RD_COUNT = 8'h0c;
  // Control fields and reset value
  localparam int CTRL_WR_BLOCK_BIT = 0;    // Suppress array writes
  localparam int CTRL_CNT_CLR_BIT = 1;     // Clear both cycle counters
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status fields
  localparam int STAT_IDX_LSB = 0;         // Two-bit burst position
  localparam int STAT_ACT_BIT = 2;         // Burst in progress
  localparam int STAT_SEL_BIT = 3;         // Selected this cycle
  localparam int STAT_STATE_LSB = 4;       // Four-bit one-hot power state
  // Bus transfer type and response code
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // Burst order select level
  localparam logic ORDER_LINEAR = 1'b0;
  // Power states
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_STANDBY = 4'b0010,
    ST_RECOVER = 4'b0100,
    ST_LOWPWR = 4'b1000
  } pwr_state_t;
endpackage
`default_nettype wire

// ===== src/burst_addr_gen.sv
// Low address bits of a burst from start bits, position and order
`default_nettype none
module burst_addr_gen
  import sram_ctl_pkg::*;
(
  // Burst inputs
  input wire logic [1:0] start_lsb,
  input wire logic [1:0] idx,
  input wire logic burst_order_sel,
  // Result
  output logic [1:0] addr_lsb
);
  // Interleaved order flips bits, linear order counts modulo four
  function automatic logic [1:0] next_lsb(input logic [1:0] s,
                                          input logic [1:0] i,
                                          input logic ord);
    if (ord == ORDER_LINEAR) begin
      next_lsb = 2'(s + i);
    end else begin
      next_lsb = s ^ i;
    end
  endfunction

  // Order pin is used as a level straight from the pin
  always_comb begin
    addr_lsb = next_lsb(start_lsb, idx, burst_order_sel);
  end
endmodule // burst_addr_gen
`default_nettype wire

// ===== src/byte_write_decode.sv
// Decode of global write, write enable and lane strobes
`default_nettype none
module byte_write_decode
  import sram_ctl_pkg::*;
#(
  parameter int NLANES = LANES
) (
  // Sampled strobes, all active low
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [NLANES-1:0] byte_lane_strobe_n,
  // Decoded cycle
  output logic is_write,
  output logic [NLANES-1:0] lane_wr
);
  // Only the two-lane and four-lane organisations exist
  if (NLANES != 2 && NLANES != 4) begin : g_bad_lanes
    $error("byte_write_decode: NLANES must be 2 or 4");
  end

  // One decode per lane; global write overrides everything
  for (genvar g = 0; g < NLANES; g++) begin : g_lane
    always_comb begin
      lane_wr[g] = !global_write_n ||
                   (!byte_write_enable_n && !byte_lane_strobe_n[g]);
    end
  end

  // A write needs some lane enabled, otherwise the cycle reads
  always_comb begin
    is_write = |lane_wr;
  end
endmodule // byte_write_decode
`default_nettype wire

// ===== dv/sram_host_model.sv
// Host-side model that drives the RAM control pins
`default_nettype none
module sram_host_model
  import sram_ctl_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Address and burst control
  output logic [ADDR_W-1:0] addr_in,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_advance_n,
  // Selects
  output logic select_primary_n,
  output logic select_expand_hi,
  output logic select_expand_n,
  // Write controls
  output logic global_write_n,
  output logic byte_write_enable_n,
  output logic [LANES-1:0] byte_lane_strobe_n,
  // Static order pins and sleep
  output logic ord_lin,
  output logic ord_ilv,
  output logic sleep_req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Order pins never move, since the RAM does not latch them
  assign ord_lin = ORDER_LINEAR;
  assign ord_ilv = ~ORDER_LINEAR;

  // Quiet pins from time zero
  initial begin
    sleep_req = 1'b0;
    ctrl_addr_strobe_n = 1'b1;
    proc_addr_strobe_n = 1'b1;
    burst_advance_n = 1'b1;
    {select_primary_n, select_expand_hi, select_expand_n} = 3'b010;
    global_write_n = 1'b1;
    byte_write_enable_n = 1'b1;
    byte_lane_strobe_n = '1;
    addr_in = '0;
  end

  // One pin set just after an edge; outputs show it two edges later
  task automatic cmd(input logic c, input logic p, input logic a,
                     input logic [2:0] s, input logic g, input logic w,
                     input logic [LANES-1:0] b,
                     input logic [ADDR_W-1:0] ad);
    @(posedge clk_sys);
    ctrl_addr_strobe_n <= c;
    proc_addr_strobe_n <= p;
    burst_advance_n <= a;
    {select_primary_n, select_expand_hi, select_expand_n} <= s;
    global_write_n <= g;
    byte_write_enable_n <= w;
    byte_lane_strobe_n <= b;
    addr_in <= ad;
    #1;
  endtask

  // Cycles with no strobe and no write signal
  task automatic idle(input int n);
    repeat (n) cmd(1'b1, 1'b1, 1'b1, 3'b010, 1'b1, 1'b1, '1, '0);
  endtask

  // No command in the cycles that precede sleep
  task automatic sleep_on;
    idle(SLEEP_STANDBY_CYCLES);
    @(posedge clk_sys);
    sleep_req <= 1'b1;
    #1;
  endtask

  // Release, then sit out the synchroniser and the recovery span
  task automatic sleep_off;
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    #1;
    idle(2 + SLEEP_RECOVERY_CYCLES);
  endtask
endmodule // sram_host_model
`default_nettype wire

// ===== dv/sync_sram_burst_write_decode_tb.sv
// Self-checking bench: write decode, selects, bursts, sleep, status bus
`default_nettype none
module sync_sram_burst_write_decode_tb
  import sram_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Bus side
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = '0;
  logic hready_l, hready_i;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  // Pins from the host model
  logic [ADDR_W-1:0] addr_in;
  logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  logic select_primary_n, select_expand_hi, select_expand_n;
  logic global_write_n, byte_write_enable_n, sleep_req;
  logic [LANES-1:0] byte_lane_strobe_n;
  logic ord_lin, ord_ilv;
  // Array side; a second instance shows the other burst order
  logic [ADDR_W-1:0] a_l, a_i;
  logic [LANES-1:0] mem_wr_lane_q;
  logic mem_rd_q, mem_sel_q, asleep_q;
  // Strobes of the interleaved instance, checked alongside
  logic [LANES-1:0] lane_i;
  logic rd_i, sel_i, slp_i;
  int failures = 0;
  int comparisons = 0;

  // Free-running clock
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  sram_host_model host_u (.clk_sys, .addr_in, .proc_addr_strobe_n,
    .ctrl_addr_strobe_n, .burst_advance_n, .select_primary_n,
    .select_expand_hi, .select_expand_n, .global_write_n,
    .byte_write_enable_n, .byte_lane_strobe_n, .ord_lin, .ord_ilv,
    .sleep_req);

  sync_sram_burst_write_decode dut_u (.clk_sys, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hready_l),
    .hreadyout(hready_l), .hrdata, .hresp, .addr_in, .proc_addr_strobe_n,
    .ctrl_addr_strobe_n, .burst_advance_n, .select_primary_n,
    .select_expand_hi, .select_expand_n, .global_write_n,
    .byte_write_enable_n, .byte_lane_strobe_n, .burst_order_sel(ord_lin),
    .sleep_req, .mem_addr_q(a_l), .mem_wr_lane_q, .mem_rd_q, .mem_sel_q,
    .asleep_q);

  sync_sram_burst_write_decode dut_i (.clk_sys, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hready_i),
    .hreadyout(hready_i), .hrdata(), .hresp(), .addr_in,
    .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
    .select_primary_n, .select_expand_hi, .select_expand_n, .global_write_n,
    .byte_write_enable_n, .byte_lane_strobe_n, .burst_order_sel(ord_ilv),
    .sleep_req, .mem_addr_q(a_i), .mem_wr_lane_q(lane_i), .mem_rd_q(rd_i),
    .mem_sel_q(sel_i), .asleep_q(slp_i));

  // Verdict and end of run
  task automatic report_and_stop;
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare one value; unknown bits never match
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait for ready at an edge, giving up after a bound
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready_l !== 1'b1 && n < 20);
    if (hready_l !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask

  // Single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // Lanes a cycle should write, from global, enable and strobes
  function automatic logic [LANES-1:0] lanes_of(input logic [5:0] r);
    if (!r[5]) return '1;
    if (!r[4]) return ~r[3:0];
    return '0;
  endfunction

  initial begin
    logic [31:0] d;
    logic [LANES-1:0] l;
    logic [5:0] tbl [9];
    tbl = '{6'h30, 6'h2f, 6'h2e, 6'h2d, 6'h2b, 6'h27, 6'h20, 6'h1f, 6'h0a};
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    // Quiet outputs straight after reset
    chk("reset", 32'h0800_0000, 32'({hready_l, hresp, asleep_q, mem_sel_q,
        mem_rd_q, mem_wr_lane_q, a_l}));
    // Control readback; the clear bit does not stick
    ahb(1'b1, REG_CTRL, 32'h3, d);
    ahb(1'b0, REG_CTRL, 32'h0, d);
    chk("ctrl", 32'h1 << CTRL_WR_BLOCK_BIT, d);
    ahb(1'b1, REG_CTRL, 32'h0, d);
    ahb(1'b0, 8'h10, 32'h0, d);
    chk("unmapped", 32'h0, d);
    // Every row of the write table, lanes and read flag
    foreach (tbl[i]) begin
      host_u.cmd(1'b0, 1'b1, 1'b1, 3'b010, tbl[i][5], tbl[i][4],
                 tbl[i][3:0], 18'h100);
      host_u.idle(2);
      l = lanes_of(tbl[i]);
      chk("lanes", 32'(l), 32'(mem_wr_lane_q));
      chk("lanes i", 32'(l), 32'(lane_i));
      chk("read", 32'({2{l == '0}}), 32'({mem_rd_q, rd_i}));
    end
    // Write block: a write start stores nothing and is not counted
    ahb(1'b1, REG_CTRL, 32'h1 << CTRL_CNT_CLR_BIT, d);
    host_u.cmd(1'b0, 1'b1, 1'b1, 3'b010, 1'b0, 1'b1, '1, '0);
    host_u.idle(2);
    ahb(1'b1, REG_CTRL, 32'h1 << CTRL_WR_BLOCK_BIT, d);
    host_u.cmd(1'b0, 1'b1, 1'b1, 3'b010, 1'b0, 1'b1, '1, '0);
    host_u.idle(2);
    chk("blocked", 32'h0, 32'({mem_rd_q, mem_wr_lane_q}));
    ahb(1'b1, REG_CTRL, 32'h0, d);
    ahb(1'b0, REG_WR_COUNT, 32'h0, d);
    chk("write count", 32'h1, d);
    // All eight select patterns on a controller start
    for (int i = 0; i < 8; i++) begin
      host_u.cmd(1'b0, 1'b1, 1'b1, i[2:0], 1'b1, 1'b1, '1, '0);
      host_u.idle(2);
      chk("select", 32'({2{i == 2}}), 32'({mem_sel_q, sel_i}));
    end
    // Bursts from every start, one step past the wrap
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 7; k++) begin
        host_u.cmd(k != 0, 1'b1, k == 0, 3'b010, 1'b1, 1'b1, '1,
                   {16'ha5c3, i[1:0]});
        if (k >= 2) begin
          chk("linear", {16'ha5c3, 2'(i + k - 2)}, 32'(a_l));
          chk("interleave", {16'ha5c3, i[1:0] ^ 2'(k - 2)}, 32'(a_i));
        end
      end
    end
    // Sleep: exact entry moment, then a refused write
    host_u.sleep_on();
    host_u.idle(2);
    chk("awake", 32'h0, 32'({asleep_q, slp_i}));
    host_u.idle(1);
    chk("asleep", 32'h3, 32'({asleep_q, slp_i}));
    host_u.cmd(1'b0, 1'b1, 1'b1, 3'b010, 1'b0, 1'b0, '0, '0);
    host_u.idle(2);
    chk("sleep lanes", 32'h0, 32'({mem_sel_q, mem_wr_lane_q}));
    ahb(1'b0, REG_STATUS, 32'h0, d);
    chk("standby", 32'(ST_STANDBY), 32'(d[STAT_STATE_LSB +: 4]));
    // Wake: low power holds until a start arrives
    host_u.sleep_off();
    host_u.idle(4);
    ahb(1'b0, REG_STATUS, 32'h0, d);
    chk("lowpwr", 32'(ST_LOWPWR), 32'(d[STAT_STATE_LSB +: 4]));
    host_u.cmd(1'b0, 1'b1, 1'b1, 3'b010, 1'b1, 1'b1, '1, '0);
    host_u.idle(3);
    ahb(1'b0, REG_STATUS, 32'h0, d);
    chk("active", 32'(ST_ACTIVE), 32'(d[STAT_STATE_LSB +: 4]));
    report_and_stop();
  end
endmodule // sync_sram_burst_write_decode_tb
`default_nettype wire
